// *** include/trip_logic_pkg.sv ***
/*
  Package for the phase-selective trip logic block: register offsets, field positions, reset values,
  operating modes and timing constants.
  Assumes a 50 MHz system clock and 32-bit AXI4-Lite register access.
*/
package trip_logic_pkg;

  // Operating modes, two-bit field of the control register.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ALL_PHASE_ONLY = 2'h1;
  localparam logic [1:0] MODE_SINGLE_OR_ALL_PHASE = 2'h2;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MIN_PULSE = 8'h04;
  localparam logic [7:0] OFS_EVOLVE = 8'h08;
  localparam logic [7:0] OFS_TRIP_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;

  // Field positions of the status and event words.
  localparam int BIT_PHASE_A = 0;
  localparam int BIT_PHASE_B = 1;
  localparam int BIT_PHASE_C = 2;
  localparam int BIT_ANY = 3;
  localparam int BIT_ALL_PHASE = 4;
  localparam int EVENT_W = 8;

  // Reset values and the limits of the settings.
  localparam logic [1:0] RST_MODE = MODE_OFF;
  localparam logic [15:0] RST_MIN_PULSE_MS = 16'd150;
  localparam logic [15:0] RST_EVOLVE_MS = 16'd1000;
  localparam logic [15:0] MIN_SETTING_MS = 16'd50;
  localparam logic [15:0] MAX_SETTING_MS = 16'd60000;
  localparam logic [7:0] RST_MASK = 8'h00;

  // Millisecond tick derived from the clock.
  localparam int CLK_HZ = 50000000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verilog/phase_trip_logic.sv ***
/*
  Phase-selective trip decision block with an AXI4-Lite register slave, pulse stretching,
  evolving-fault window, trip status and on/off event flags with an interrupt.
  Assumes request inputs come from logic on aclk and need no synchroniser.
*/
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps

// Notes on behaviour
// RL1: Mode is off, all-phase only or single/all-phase, and is off after reset.
// RL2: Every trip output stays on for at least the programmed minimum pulse, 50 to 60000 ms, default 150 ms.
// RL3: The evolving-fault wait is programmable over 50 to 60000 ms, default 1000 ms.
// RL4: The block input forces every trip output inactive.
// RL5: The single-phase request together with the phase requests picks which phase trips.
// RL6: The three-phase request trips all three phases.
// RL7: Each phase request asks for a trip of its own phase.
// RL8: The force-all-phase input widens any trip to all three phases.
// RL9: The any-trip output is on whenever any trip is generated.
// RL10: The all-phase output is on whenever the trip covers all three phases.
// RL11: Each change of a phase output or the any-trip output records an on or an off event flag.
// RL12: Software can read the state of all five trip outputs.
// RL13: With the mode off no trip output is generated.
// RL14: A fault on two phases also trips the third phase.
// RL15: While the evolving-fault window runs, any further trip covers all three phases.
// RL16: In all-phase-only mode every trip request becomes a three-phase trip.
// RL17: A single-phase trip starts the evolving-fault window and both timers run from a 1 ms tick.
module phase_trip_logic
  import trip_logic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic block_in,
  input wire logic single_phase_req,
  input wire logic three_phase_req,
  input wire logic phase_a_req,
  input wire logic phase_b_req,
  input wire logic phase_c_req,
  input wire logic force_all_phase_req,
  output logic phase_a_trip_out,
  output logic phase_b_trip_out,
  output logic phase_c_trip_out,
  output logic any_trip_out,
  output logic all_phase_trip_out,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [1:0] mode_ff, nxt_mode;
  logic [15:0] min_pulse_ff, nxt_min_pulse;
  logic [15:0] evolve_ff, nxt_evolve;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] event_ff, nxt_event;
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [15:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick;
  logic [15:0] pulse_ms_ff, nxt_pulse_ms;
  logic [15:0] evolve_ms_ff, nxt_evolve_ms;
  logic [2:0] phase_ff, nxt_phase;
  logic [2:0] req_phase;
  logic req_any, req_all, widen, trip_single;
  logic do_write;
  logic [31:0] wr_val;
  logic [3:0] prev_ff;
  logic [3:0] cur_vec;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channels with register updates.
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign do_write = (aw_got_ff || (s_axi_awvalid && s_axi_awready)) && (w_got_ff || (s_axi_wvalid && s_axi_wready));

  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_mode = mode_ff;
    nxt_min_pulse = min_pulse_ff;
    nxt_evolve = evolve_ff;
    nxt_mask = mask_ff;
    wr_val = '0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      for (int i = 0; i < 4; i++)
      begin
        wr_val[i*8 +: 8] = nxt_wstrb[i] ? nxt_wdata[i*8 +: 8] : 8'h00;
      end
      case (nxt_awaddr)
        OFS_CTRL:
        begin
          // Codes beyond the three modes are refused and the mode stays. [RL1]
          if (nxt_wstrb[0] && wr_val[1:0] != 2'h3)
            nxt_mode = wr_val[1:0];
        end
        OFS_MIN_PULSE:
        begin
          // Settings outside the documented range are clamped. [RL2]
          if (nxt_wstrb[1:0] == 2'h3)
            nxt_min_pulse = (wr_val[15:0] < MIN_SETTING_MS) ? MIN_SETTING_MS :
              (wr_val[15:0] > MAX_SETTING_MS) ? MAX_SETTING_MS : wr_val[15:0];
        end
        OFS_EVOLVE:
        begin
          if (nxt_wstrb[1:0] == 2'h3) // [RL3]
            nxt_evolve = (wr_val[15:0] < MIN_SETTING_MS) ? MIN_SETTING_MS :
              (wr_val[15:0] > MAX_SETTING_MS) ? MAX_SETTING_MS : wr_val[15:0];
        end
        OFS_MASK:
        begin
          if (nxt_wstrb[0])
            nxt_mask = wr_val[7:0];
        end
        OFS_EVENT, OFS_TRIP_STATUS: ;
        default: nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CTRL: nxt_rdata = {30'h0, mode_ff};
        OFS_MIN_PULSE: nxt_rdata = {16'h0, min_pulse_ff};
        OFS_EVOLVE: nxt_rdata = {16'h0, evolve_ff};
        OFS_TRIP_STATUS: nxt_rdata = {27'h0, all_phase_trip_out, any_trip_out, phase_ff}; // [RL12]
        OFS_EVENT: nxt_rdata = {24'h0, event_ff};
        OFS_MASK: nxt_rdata = {24'h0, mask_ff};
        default:
        begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Registers of the bus slave and the settings.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      mode_ff <= RST_MODE; // [RL1]
      min_pulse_ff <= RST_MIN_PULSE_MS;
      evolve_ff <= RST_EVOLVE_MS;
      mask_ff <= RST_MASK;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      mode_ff <= nxt_mode;
      min_pulse_ff <= nxt_min_pulse;
      evolve_ff <= nxt_evolve;
      mask_ff <= nxt_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trip decision: requested phases, widening, pulse stretching and evolving window.
  assign tick = (tick_cnt_ff == 16'(TICK_CYCLES - 1)); // [RL17]
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      req_phase[i] = 1'b0;
    req_phase[0] = phase_a_req;
    req_phase[1] = phase_b_req;
    req_phase[2] = phase_c_req;
    // A three-phase request trips on its own; a lone single-phase flag names no phase. [RL5] [RL6] [RL7]
    req_any = (|req_phase) || three_phase_req;
    // Two phases, explicit three-phase, forcing or mode widen to all phases. [RL6] [RL8] [RL14] [RL16]
    // The window widens only a further trip (a new phase or a fresh one), so the request that opened it
    // keeps its single phase while it stands. [RL15]
    widen = three_phase_req || force_all_phase_req || (mode_ff == MODE_ALL_PHASE_ONLY) ||
            ((evolve_ms_ff != 16'h0) && ((phase_ff == 3'h0) || (|(req_phase & ~phase_ff)))) ||
            ((req_phase[0] & req_phase[1]) | (req_phase[1] & req_phase[2]) | (req_phase[0] & req_phase[2]));
    req_all = req_any && widen;
    trip_single = req_any && !widen;
    nxt_tick_cnt = tick ? 16'h0 : tick_cnt_ff + 16'h1;
    nxt_phase = phase_ff;
    nxt_pulse_ms = pulse_ms_ff;
    nxt_evolve_ms = evolve_ms_ff;
    if (tick && pulse_ms_ff != 16'h0)
      nxt_pulse_ms = pulse_ms_ff - 16'h1;
    if (tick && evolve_ms_ff != 16'h0)
      nxt_evolve_ms = evolve_ms_ff - 16'h1;
    if (tick && pulse_ms_ff == 16'h1 && !req_any)
      nxt_phase = 3'h0; // Release only after the minimum pulse. [RL2]
    if (req_any)
    begin
      nxt_phase = phase_ff | (req_all ? 3'h7 : req_phase);
      nxt_pulse_ms = min_pulse_ff; // [RL2]
    end
    // Only phase requests flagged as single-phase arm the evolving-fault window. [RL5]
    if (trip_single && single_phase_req && phase_ff == 3'h0)
      nxt_evolve_ms = evolve_ff; // [RL17]
    if (block_in || mode_ff == MODE_OFF)
    begin
      nxt_phase = 3'h0; // [RL4] [RL13]
      nxt_pulse_ms = 16'h0;
      nxt_evolve_ms = 16'h0;
    end
  end

  // Trip state registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_ff <= 16'h0;
      pulse_ms_ff <= 16'h0;
      evolve_ms_ff <= 16'h0;
      phase_ff <= 3'h0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      pulse_ms_ff <= nxt_pulse_ms;
      evolve_ms_ff <= nxt_evolve_ms;
      phase_ff <= nxt_phase;
    end
  end

  assign phase_a_trip_out = phase_ff[0];
  assign phase_b_trip_out = phase_ff[1];
  assign phase_c_trip_out = phase_ff[2];
  assign any_trip_out = |phase_ff; // [RL9]
  assign all_phase_trip_out = &phase_ff; // [RL10]

  ////////////////////////////////////////////////////////////////////////////////
  // On/off events: bits 3:0 rise of A,B,C,any; bits 7:4 fall. Set wins over write-one-clear.
  assign cur_vec = {any_trip_out, phase_ff};
  always_comb
  begin
    nxt_event = event_ff;
    if (do_write && nxt_awaddr == OFS_EVENT && nxt_wstrb[0])
      nxt_event = event_ff & ~nxt_wdata[7:0];
    nxt_event = nxt_event | {prev_ff & ~cur_vec, cur_vec & ~prev_ff}; // [RL11]
  end

  // Event flags and previous output state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_ff <= 8'h00;
      prev_ff <= 4'h0;
    end
    else
    begin
      event_ff <= nxt_event;
      prev_ff <= cur_vec;
    end
  end

  assign irq = |(event_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_block_clears;
    @(posedge aclk) disable iff (!aresetn) block_in |=> (phase_ff == 3'h0);
  endproperty
  a_block_clears: assert property (p_block_clears) else $error("Trip active after block."); // [RL4]

  property p_off_clears;
    @(posedge aclk) disable iff (!aresetn) (mode_ff == MODE_OFF) |=> !any_trip_out;
  endproperty
  a_off_clears: assert property (p_off_clears) else $error("Trip active in off mode."); // [RL13]

  property p_three_phase;
    @(posedge aclk) disable iff (!aresetn)
      (three_phase_req && !block_in && mode_ff != MODE_OFF) |=> all_phase_trip_out;
  endproperty
  a_three_phase: assert property (p_three_phase) else $error("Three-phase request not honoured."); // [RL6]

  property p_force;
    @(posedge aclk) disable iff (!aresetn)
      (force_all_phase_req && phase_a_req && !block_in && mode_ff != MODE_OFF) |=> (phase_ff == 3'h7);
  endproperty
  a_force: assert property (p_force) else $error("Forced trip not on all phases."); // [RL8]

  property p_two_phase;
    @(posedge aclk) disable iff (!aresetn)
      (phase_a_req && phase_b_req && !block_in && mode_ff != MODE_OFF) |=> phase_c_trip_out;
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("Third phase missing."); // [RL14]

  property p_mode_all;
    @(posedge aclk) disable iff (!aresetn)
      (mode_ff == MODE_ALL_PHASE_ONLY && phase_b_req && !block_in) |=> all_phase_trip_out;
  endproperty
  a_mode_all: assert property (p_mode_all) else $error("All-phase mode gave partial trip."); // [RL16]

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      (any_trip_out && pulse_ms_ff > 16'h1 && !block_in && mode_ff != MODE_OFF) |=> any_trip_out;
  endproperty
  a_hold: assert property (p_hold) else $error("Trip dropped before minimum pulse."); // [RL2]

  property p_any;
    @(posedge aclk) disable iff (!aresetn) (phase_ff != 3'h0) |-> any_trip_out && (all_phase_trip_out == (phase_ff == 3'h7));
  endproperty
  a_any: assert property (p_any) else $error("General or all-phase output wrong."); // [RL9]

  property p_event;
    @(posedge aclk) disable iff (!aresetn) $rose(any_trip_out) |=> event_ff[BIT_ANY];
  endproperty
  a_event: assert property (p_event) else $error("Trip on event not recorded."); // [RL11]

endmodule

// *** verification/trip_source.sv ***
/*
  Stand-in for the upstream protection functions that feed the trip logic.
  Assumes the bench hands it a request word; it drives the request pins from a flop on aclk.
*/
`timescale 1ns/1ps

module trip_source
(
  input wire logic aclk,
  input wire logic [6:0] cmd,
  output logic block_in,
  output logic single_phase_req,
  output logic three_phase_req,
  output logic phase_a_req,
  output logic phase_b_req,
  output logic phase_c_req,
  output logic force_all_phase_req
);
  // Requests change only just after a rising edge, as clocked upstream logic would drive them.
  always_ff @(posedge aclk)
  begin
    {block_in, single_phase_req, three_phase_req, phase_a_req, phase_b_req, phase_c_req,
     force_all_phase_req} <= cmd;
  end
endmodule

// *** verification/tb_phase_selective_trip_logic.sv ***
/*
  Self-checking bench for the trip logic: a table of request cases, then register, stretch,
  evolving-fault and event tests.
  Assumes the 1 ms tick is not shortened, so pulse expiry itself is not waited for.
*/
`timescale 1ns/1ps

module tb_phase_selective_trip_logic
  import trip_logic_pkg::*;
;
  typedef struct packed {logic [1:0] mode; logic [6:0] req; logic [2:0] exp;} row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [6:0] cmd;
  logic blk, sp, tp, ra, rb, rc, fr, ta, tb, tc, tany, tall;
  int failures, n_checks;
  logic [7:0] ofs [5] = '{OFS_CTRL, OFS_MIN_PULSE, OFS_EVOLVE, OFS_MASK, OFS_TRIP_STATUS};
  logic [31:0] rst [5] = '{32'h0, 32'h96, 32'h3E8, 32'h0, 32'h0};
  // Request bits are block, single, three, A, B, C, force; expected trips are C, B, A.
  row_t rows [12] = '{'{2'h2, 7'h28, 3'h1}, '{2'h2, 7'h08, 3'h1}, '{2'h2, 7'h02, 3'h4}, '{2'h2, 7'h10, 3'h7},
    '{2'h2, 7'h0C, 3'h7}, '{2'h2, 7'h29, 3'h7}, '{2'h1, 7'h24, 3'h7}, '{2'h0, 7'h10, 3'h0},
    '{2'h2, 7'h50, 3'h0}, '{2'h2, 7'h20, 3'h0}, '{2'h3, 7'h08, 3'h0}, '{2'h2, 7'h30, 3'h7}};

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, far-side model and design.
  always #10 aclk = ~aclk;
  trip_source trip_source_i (.aclk(aclk), .cmd(cmd), .block_in(blk), .single_phase_req(sp),
    .three_phase_req(tp), .phase_a_req(ra), .phase_b_req(rb), .phase_c_req(rc), .force_all_phase_req(fr));
  phase_trip_logic phase_trip_logic_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .block_in(blk),
    .single_phase_req(sp), .three_phase_req(tp), .phase_a_req(ra), .phase_b_req(rb), .phase_c_req(rc),
    .force_all_phase_req(fr), .phase_a_trip_out(ta), .phase_b_trip_out(tb), .phase_c_trip_out(tc),
    .any_trip_out(tany), .all_phase_trip_out(tall), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks; a handshake seen at the falling edge completes at the next rise.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
    logic aw_ok, w_ok, b_ok;
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok)
    begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    // An idle edge keeps a following call from raising bready in the step that lowers it.
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [7:0] addr);
    logic ar_ok, r_ok;
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok)
    begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic do_reset();
    cmd <= 7'h00;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // Lets a request reach the design and its outputs settle, then stops at a falling edge for the caller to sample them.
  task automatic settle(input logic [6:0] c);
    cmd <= c;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  function automatic logic [31:0] trips();
    return {27'h0, tall, tany, tc, tb, ta};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake.
  initial
  begin
    #1000000;
    failures++;
    finish_test();
  end

  // Main sequence: the case table, then the hand-written tests.
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd, failures, n_checks} = '0;
    @(posedge aclk);
    for (int i = 0; i < 12; i++)
    begin
      do_reset();
      axi_write(OFS_CTRL, {30'h0, rows[i].mode});
      settle(rows[i].req);
      check("trips", trips(), {27'h0, &rows[i].exp, |rows[i].exp, rows[i].exp});
      @(posedge aclk);
    end
    do_reset();
    for (int i = 0; i < 5; i++)
    begin
      axi_read(ofs[i]);
      check("reset value", rd, rst[i]);
    end
    axi_read(8'h20);
    check("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(8'h20, 32'h00000000);
    check("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(OFS_MIN_PULSE, 32'h0000000A);
    check("write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
    axi_read(OFS_MIN_PULSE);
    check("pulse low clamp", rd, 32'h32);
    axi_write(OFS_MIN_PULSE, 32'h0000FFFF);
    axi_read(OFS_MIN_PULSE);
    check("pulse high clamp", rd, 32'hEA60);
    axi_write(OFS_EVOLVE, 32'h0000000A);
    axi_read(OFS_EVOLVE);
    check("evolve clamp", rd, 32'h32);
    do_reset();
    axi_write(OFS_MASK, 32'h000000FF);
    axi_write(OFS_CTRL, {30'h0, MODE_SINGLE_OR_ALL_PHASE});
    settle(7'h28);
    @(posedge aclk);
    axi_read(OFS_TRIP_STATUS);
    check("status", rd, 32'h09);
    check("irq set", {31'h0, irq}, 32'h1);
    axi_read(OFS_EVENT);
    check("on events", rd, 32'h09);
    settle(7'h00);
    repeat (1000) @(posedge aclk);
    @(negedge aclk);
    check("stretched", trips(), 32'h09);
    @(posedge aclk);
    axi_write(OFS_EVENT, 32'h000000FF);
    axi_read(OFS_EVENT);
    check("events cleared", rd, 32'h00);
    check("irq cleared", {31'h0, irq}, 32'h0);
    settle(7'h04);
    check("evolving widen", trips(), 32'h1F);
    @(posedge aclk);
    axi_write(OFS_MASK, 32'h00000000);
    settle(7'h40);
    check("blocked", trips(), 32'h00);
    @(posedge aclk);
    axi_read(OFS_EVENT);
    check("off events", rd, 32'hF6);
    check("irq masked", {31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
